// ===== bopx_pkg.sv
// Shared constants, field layout and types for the byte-operation executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
`default_nettype none

package bopx_pkg;

  // Data path and instruction widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_N = 128;
  localparam int unsigned FLAG_W = 3;
  localparam int unsigned DIR_N = 3;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Instruction field positions
  localparam int unsigned CLS_HI = 13;
  localparam int unsigned CLS_LO = 12;
  localparam int unsigned OPC_HI = 11;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned LITSEL_HI = 11;
  localparam int unsigned LITSEL_LO = 10;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned MISC_HI = 7;
  localparam int unsigned MISC_LO = 3;
  localparam int unsigned DSEL_HI = 2;

  // Instruction field codes
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [1:0] LITSEL_LOAD = 2'h0;
  localparam logic [3:0] OPC_MISC = 4'h0;
  localparam logic [3:0] OPC_SUB = 4'h2;
  localparam logic [3:0] OPC_OR = 4'h4;
  localparam logic [3:0] OPC_COPY = 4'h8;
  localparam logic [3:0] OPC_RR = 4'hc;
  localparam logic [3:0] OPC_RL = 4'hd;
  localparam logic [3:0] OPC_SWAP = 4'he;
  localparam logic [4:0] MISC_DIRLD = 5'h0c;
  localparam logic [2:0] DIR_FIRST = 3'h5;

  // Status flag positions
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_NIB = 1;
  localparam int unsigned FLG_C = 0;

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] REG_ACCUM = 8'h08;
  localparam logic [APB_AW-1:0] REG_WADDR = 8'h0c;
  localparam logic [APB_AW-1:0] REG_WDATA = 8'h10;
  localparam logic [APB_AW-1:0] REG_DIR = 8'h14;
  localparam logic [APB_AW-1:0] REG_INSTR = 8'h18;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ACCUM = 8'h00;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 3'h0;
  localparam logic [DATA_W-1:0] RST_DIR = 8'hff;
  localparam logic [DATA_W-1:0] RST_FILE = 8'h00;

  // Quarter phases of one instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } bopx_phase_t;

  // Decoded operation
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_OR_ACCUM_WITH_FILE = 4'h1,
    OP_COPY_FILE_REG = 4'h2,
    OP_LOAD_LITERAL_TO_ACCUM = 4'h3,
    OP_STORE_ACCUM_TO_FILE = 4'h4,
    OP_ROTATE_LEFT_THRU_CARRY = 4'h5,
    OP_ROTATE_RIGHT_THRU_CARRY = 4'h6,
    OP_SUB_ACCUM_FROM_FILE = 4'h7,
    OP_NIBBLE_EXCHANGE = 4'h8,
    OP_LEGACY_DIRECTION_LOAD = 4'h9
  } bopx_op_t;

endpackage : bopx_pkg

`default_nettype wire

// ===== bopx_decode.sv
// Instruction decoder: classifies a 14-bit word and splits its operands.
// Assumes a held instruction word from the executor on the same clock.
`timescale 1ns/1ps
`default_nettype none

module bopx_decode (
  input wire logic [bopx_pkg::INSTR_W-1:0] instr,
  output bopx_pkg::bopx_op_t op,
  output logic [bopx_pkg::FADDR_W-1:0] faddr,
  output logic to_file,
  output logic [bopx_pkg::DATA_W-1:0] literal
);

  // Map an instruction word onto an operation, unknown words become no-ops
  function automatic bopx_pkg::bopx_op_t bopx_classify(input logic [13:0] w);
    bopx_pkg::bopx_op_t r;
    r = bopx_pkg::OP_NOP;
    if (w[bopx_pkg::CLS_HI:bopx_pkg::CLS_LO] == bopx_pkg::CLS_LIT) begin
      // [RULE_05] literal select bits 11:10 must be zero to load, bits 9:8 ignored
      if (w[bopx_pkg::LITSEL_HI:bopx_pkg::LITSEL_LO] == bopx_pkg::LITSEL_LOAD) begin
        r = bopx_pkg::OP_LOAD_LITERAL_TO_ACCUM;
      end
    end else if (w[bopx_pkg::CLS_HI:bopx_pkg::CLS_LO] == bopx_pkg::CLS_BYTE) begin
      case (w[bopx_pkg::OPC_HI:bopx_pkg::OPC_LO])
        bopx_pkg::OPC_OR: r = bopx_pkg::OP_OR_ACCUM_WITH_FILE;
        bopx_pkg::OPC_COPY: r = bopx_pkg::OP_COPY_FILE_REG;
        bopx_pkg::OPC_RL: r = bopx_pkg::OP_ROTATE_LEFT_THRU_CARRY;
        bopx_pkg::OPC_RR: r = bopx_pkg::OP_ROTATE_RIGHT_THRU_CARRY;
        bopx_pkg::OPC_SUB: r = bopx_pkg::OP_SUB_ACCUM_FROM_FILE;
        bopx_pkg::OPC_SWAP: r = bopx_pkg::OP_NIBBLE_EXCHANGE;
        bopx_pkg::OPC_MISC: begin
          if (w[bopx_pkg::DEST_BIT]) begin
            r = bopx_pkg::OP_STORE_ACCUM_TO_FILE;
          end else if (w[bopx_pkg::MISC_HI:bopx_pkg::MISC_LO] == bopx_pkg::MISC_DIRLD) begin
            r = bopx_pkg::OP_LEGACY_DIRECTION_LOAD;
          end
        end
        default: r = bopx_pkg::OP_NOP;
      endcase
    end
    return r;
  endfunction : bopx_classify

  // Operation and operand fields
  assign op = bopx_classify(instr);
  // [RULE_15] address and destination bit
  assign faddr = instr[bopx_pkg::FADDR_W-1:0];
  assign to_file = instr[bopx_pkg::DEST_BIT];
  assign literal = instr[bopx_pkg::DATA_W-1:0];

endmodule : bopx_decode

`default_nettype wire

// ===== bopx_alu.sv
// Result and status flag computation for one decoded operation.
// Assumes operands held stable in registers by the executor.
`timescale 1ns/1ps
`default_nettype none

module bopx_alu (
  input wire bopx_pkg::bopx_op_t op,
  input wire logic [bopx_pkg::DATA_W-1:0] accum,
  input wire logic [bopx_pkg::DATA_W-1:0] fval,
  input wire logic [bopx_pkg::DATA_W-1:0] literal,
  input wire logic [bopx_pkg::FLAG_W-1:0] flags_in,
  output logic [bopx_pkg::DATA_W-1:0] result,
  output logic [bopx_pkg::FLAG_W-1:0] flags_out
);

  logic [bopx_pkg::DATA_W:0] diff;
  logic [4:0] nib_diff;

  // Two's complement add of the inverted accumulator
  assign diff = {1'b0, fval} + {1'b0, ~accum} + 9'h001;
  assign nib_diff = {1'b0, fval[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;

  // Result and flags per operation, untouched flags pass through
  always_comb begin
    result = fval;
    flags_out = flags_in;
    case (op)
      // [RULE_01] or, zero only
      bopx_pkg::OP_OR_ACCUM_WITH_FILE: begin
        result = accum | fval;
        flags_out[bopx_pkg::FLG_Z] = ((accum | fval) == 8'h00);
      end
      // [RULE_03] copy tests zero
      bopx_pkg::OP_COPY_FILE_REG: begin
        result = fval;
        flags_out[bopx_pkg::FLG_Z] = (fval == 8'h00);
      end
      // [RULE_04] literal, flags kept
      bopx_pkg::OP_LOAD_LITERAL_TO_ACCUM: result = literal;
      // [RULE_06] store, flags kept
      bopx_pkg::OP_STORE_ACCUM_TO_FILE: result = accum;
      // [RULE_12] direction value, flags kept
      bopx_pkg::OP_LEGACY_DIRECTION_LOAD: result = accum;
      // [RULE_07] [RULE_18] [RULE_19] left through carry
      bopx_pkg::OP_ROTATE_LEFT_THRU_CARRY: begin
        result = {fval[6:0], flags_in[bopx_pkg::FLG_C]};
        flags_out[bopx_pkg::FLG_C] = fval[7];
      end
      // [RULE_08] [RULE_18] [RULE_19] right through carry
      bopx_pkg::OP_ROTATE_RIGHT_THRU_CARRY: begin
        result = {flags_in[bopx_pkg::FLG_C], fval[7:1]};
        flags_out[bopx_pkg::FLG_C] = fval[0];
      end
      // [RULE_09] [RULE_10] [RULE_16] [RULE_17] subtract with inverted borrows
      bopx_pkg::OP_SUB_ACCUM_FROM_FILE: begin
        result = diff[bopx_pkg::DATA_W-1:0];
        flags_out[bopx_pkg::FLG_C] = diff[bopx_pkg::DATA_W];
        flags_out[bopx_pkg::FLG_NIB] = nib_diff[4];
        flags_out[bopx_pkg::FLG_Z] = (diff[bopx_pkg::DATA_W-1:0] == 8'h00);
      end
      // [RULE_11] nibble swap, flags kept
      bopx_pkg::OP_NIBBLE_EXCHANGE: result = {fval[3:0], fval[7:4]};
      default: result = fval;
    endcase
  end

endmodule : bopx_alu

`default_nettype wire

// ===== bopx_core.sv
// Executor for a subset of byte-oriented 14-bit instructions, APB control.
// Assumes program memory on pclk presents words with a valid/ready handshake.
//
// Notes on behaviour
// [RULE_01] OR accumulator with file, zero flag only
// [RULE_02] Destination bit 0 accumulator, 1 file
// [RULE_03] Copy file to destination, updates zero
// [RULE_04] Literal loads accumulator, flags unchanged
// [RULE_05] Literal don't-care bits never affect execution
// [RULE_06] Store accumulator into file, flags unchanged
// [RULE_07] Rotate left through carry, carry only
// [RULE_08] Rotate right through carry, carry only
// [RULE_09] Subtract accumulator from file, three flags
// [RULE_10] Subtract carry set when result not negative
// [RULE_11] Swap nibbles of file, no flags
// [RULE_12] Legacy load copies accumulator to direction 5-7
// [RULE_13] Software should write direction registers directly; REG_DIR here is read-only, writes are ignored
// [RULE_14] One cycle of four quarter phases
// [RULE_15] Seven-bit file address, destination in bit 7
// [RULE_16] Zero flag set on zero result
// [RULE_17] Nibble carry from bit 3, inverted borrow
// [RULE_18] Rotate carry takes shifted-out source bit
// [RULE_19] Old carry enters the vacated bit
// [RULE_20] Eight-bit accumulator, writes at fourth phase
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module bopx_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bopx_pkg::APB_AW-1:0] paddr,
  input wire logic [bopx_pkg::APB_DW-1:0] pwdata,
  output logic [bopx_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [bopx_pkg::INSTR_W-1:0] instr_data,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [bopx_pkg::DATA_W-1:0] accum_out,
  output logic [bopx_pkg::FLAG_W-1:0] flags_out,
  output logic [3:0] phase_out,
  output logic [bopx_pkg::DIR_N*bopx_pkg::DATA_W-1:0] dir_out
);

  // Whole module state
  typedef struct packed {
    bopx_pkg::bopx_phase_t phase;
    logic run;
    logic [bopx_pkg::INSTR_W-1:0] instr;
    logic [bopx_pkg::DATA_W-1:0] accum;
    logic [bopx_pkg::FLAG_W-1:0] flags;
    logic [bopx_pkg::DATA_W-1:0] operand;
    logic [bopx_pkg::DATA_W-1:0] result;
    logic [bopx_pkg::FLAG_W-1:0] res_flags;
    logic [bopx_pkg::FADDR_W-1:0] win_addr;
    logic [bopx_pkg::FILE_N-1:0][bopx_pkg::DATA_W-1:0] file;
    logic [bopx_pkg::DIR_N-1:0][bopx_pkg::DATA_W-1:0] dir;
    logic [bopx_pkg::APB_DW-1:0] prdata;
  } bopx_state_t;

  localparam bopx_state_t ST_RESET = '{
    phase: bopx_pkg::PH_Q1,
    run: 1'b0,
    instr: '0,
    accum: bopx_pkg::RST_ACCUM,
    flags: bopx_pkg::RST_FLAGS,
    operand: '0,
    result: '0,
    res_flags: '0,
    win_addr: '0,
    file: {bopx_pkg::FILE_N{bopx_pkg::RST_FILE}},
    dir: {bopx_pkg::DIR_N{bopx_pkg::RST_DIR}},
    prdata: '0
  };

  bopx_state_t s_q;
  bopx_state_t s_d;

  bopx_pkg::bopx_op_t dec_op;
  logic [bopx_pkg::FADDR_W-1:0] dec_faddr;
  logic dec_to_file;
  logic [bopx_pkg::DATA_W-1:0] dec_literal;
  logic [bopx_pkg::DATA_W-1:0] alu_result;
  logic [bopx_pkg::FLAG_W-1:0] alu_flags;
  logic [2:0] dir_sel;
  logic [1:0] dir_idx;
  logic dir_hit;
  logic apb_access;
  logic apb_wr;

  // True for any offset that has a register behind it
  function automatic logic bopx_mapped(input logic [bopx_pkg::APB_AW-1:0] a);
    return (a == bopx_pkg::REG_CTRL) || (a == bopx_pkg::REG_STATUS) ||
           (a == bopx_pkg::REG_ACCUM) || (a == bopx_pkg::REG_WADDR) ||
           (a == bopx_pkg::REG_WDATA) || (a == bopx_pkg::REG_DIR) ||
           (a == bopx_pkg::REG_INSTR);
  endfunction : bopx_mapped

  // Decoder on the held instruction
  bopx_decode u_decode (
    .instr(s_q.instr),
    .op(dec_op),
    .faddr(dec_faddr),
    .to_file(dec_to_file),
    .literal(dec_literal)
  );

  // Result and flags from the operand read in the second phase
  bopx_alu u_alu (
    .op(dec_op),
    .accum(s_q.accum),
    .fval(s_q.operand),
    .literal(dec_literal),
    .flags_in(s_q.flags),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // Direction register select, only operands 5 to 7 reach a register
  assign dir_sel = s_q.instr[bopx_pkg::DSEL_HI:0];
  assign dir_hit = (dir_sel >= bopx_pkg::DIR_FIRST);
  assign dir_idx = 2'(dir_sel - bopx_pkg::DIR_FIRST);

  // Bus strobes, zero wait states while the clock enable is high
  assign apb_access = psel && penable && ce;
  assign apb_wr = apb_access && pwrite;

  // Next state: bus side first, execution after so hardware updates win
  always_comb begin
    s_d = s_q;
    // Read data captured in the setup cycle
    if (psel && !penable) begin
      s_d.prdata = '0;
      case (paddr)
        bopx_pkg::REG_CTRL: s_d.prdata[0] = s_q.run;
        bopx_pkg::REG_STATUS: s_d.prdata[bopx_pkg::FLAG_W-1:0] = s_q.flags;
        bopx_pkg::REG_ACCUM: s_d.prdata[bopx_pkg::DATA_W-1:0] = s_q.accum;
        bopx_pkg::REG_WADDR: s_d.prdata[bopx_pkg::FADDR_W-1:0] = s_q.win_addr;
        bopx_pkg::REG_WDATA: s_d.prdata[bopx_pkg::DATA_W-1:0] = s_q.file[s_q.win_addr];
        bopx_pkg::REG_DIR: s_d.prdata[bopx_pkg::DIR_N*bopx_pkg::DATA_W-1:0] = s_q.dir;
        bopx_pkg::REG_INSTR: s_d.prdata[bopx_pkg::INSTR_W-1:0] = s_q.instr;
        default: s_d.prdata = '0;
      endcase
    end
    // Register writes in the access phase
    if (apb_wr) begin
      case (paddr)
        bopx_pkg::REG_CTRL: s_d.run = pwdata[0];
        bopx_pkg::REG_STATUS: s_d.flags = pwdata[bopx_pkg::FLAG_W-1:0];
        bopx_pkg::REG_ACCUM: s_d.accum = pwdata[bopx_pkg::DATA_W-1:0];
        bopx_pkg::REG_WADDR: s_d.win_addr = pwdata[bopx_pkg::FADDR_W-1:0];
        bopx_pkg::REG_WDATA: s_d.file[s_q.win_addr] = pwdata[bopx_pkg::DATA_W-1:0];
        default: s_d.run = s_d.run;
      endcase
    end
    // [RULE_14] four quarter phases per instruction
    case (s_q.phase)
      bopx_pkg::PH_Q1: begin
        // Decode phase: take the next word when running
        if (s_q.run && instr_valid) begin
          s_d.instr = instr_data;
          s_d.phase = bopx_pkg::PH_Q2;
        end
      end
      bopx_pkg::PH_Q2: begin
        // [RULE_15] operand read by address
        s_d.operand = s_q.file[dec_faddr];
        s_d.phase = bopx_pkg::PH_Q3;
      end
      bopx_pkg::PH_Q3: begin
        // Process data
        s_d.result = alu_result;
        s_d.res_flags = alu_flags;
        s_d.phase = bopx_pkg::PH_Q4;
      end
      bopx_pkg::PH_Q4: begin
        // [RULE_20] results land at the fourth phase
        s_d.flags = s_q.res_flags;
        case (dec_op)
          bopx_pkg::OP_OR_ACCUM_WITH_FILE,
          bopx_pkg::OP_COPY_FILE_REG,
          bopx_pkg::OP_ROTATE_LEFT_THRU_CARRY,
          bopx_pkg::OP_ROTATE_RIGHT_THRU_CARRY,
          bopx_pkg::OP_SUB_ACCUM_FROM_FILE,
          bopx_pkg::OP_NIBBLE_EXCHANGE: begin
            // [RULE_02] destination select
            if (dec_to_file) begin
              s_d.file[dec_faddr] = s_q.result;
            end else begin
              s_d.accum = s_q.result;
            end
          end
          bopx_pkg::OP_LOAD_LITERAL_TO_ACCUM: s_d.accum = s_q.result;
          // [RULE_06] accumulator into file
          bopx_pkg::OP_STORE_ACCUM_TO_FILE: s_d.file[dec_faddr] = s_q.result;
          bopx_pkg::OP_LEGACY_DIRECTION_LOAD: begin
            // [RULE_12] operands 5 to 7 only
            if (dir_hit) begin
              s_d.dir[dir_idx] = s_q.result;
            end
          end
          default: s_d.flags = s_q.res_flags;
        endcase
        s_d.phase = bopx_pkg::PH_Q1;
      end
      default: s_d.phase = bopx_pkg::PH_Q1;
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= ST_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Bus answer
  assign prdata = s_q.prdata;
  assign pready = apb_access;
  assign pslverr = apb_access && !bopx_mapped(paddr);

  // Instruction handshake and visible state
  assign instr_ready = ce && s_q.run && (s_q.phase == bopx_pkg::PH_Q1);
  assign accum_out = s_q.accum;
  assign flags_out = s_q.flags;
  assign phase_out = s_q.phase;
  assign dir_out = s_q.dir;

endmodule : bopx_core

`default_nettype wire

// ===== bopx_core_checker.sv
// Concurrent checks on the executor's top-level ports.
// Assumes a single pclk domain; bound onto every bopx_core instance.
`timescale 1ns/1ps
`default_nettype none

module bopx_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [13:0] instr_data,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [7:0] accum_out,
  input wire logic [2:0] flags_out,
  input wire logic [3:0] phase_out,
  input wire logic [23:0] dir_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decoded classes of the word being taken
  wire take = instr_valid && instr_ready;
  wire [5:0] hi = instr_data[13:8];
  wire [7:0] kval = instr_data[7:0];
  wire acc = psel && penable;
  wire lit = take && hi[5:2] == 4'hc;
  wire store = take && hi == 6'h00 && instr_data[7];
  wire flagfree = lit || store || (take && hi == 6'h0e);
  wire rot = take && (hi == 6'h0c || hi == 6'h0d);
  wire zonly = take && (hi == 6'h04 || hi == 6'h08);

  sequence s_walk;
    phase_out == 4'b0010 ##1 phase_out == 4'b0100 ##1 phase_out == 4'b1000
      ##1 phase_out == 4'b0001;
  endsequence

  a_quarter_walk: assert property (take |=> s_walk)
    else $error("quarter phase walk broken");
  a_ready_in_q1: assert property (instr_ready |-> phase_out == 4'b0001)
    else $error("word offered outside first quarter");
  a_ce_freezes: assert property (!ce |-> !pready && !instr_ready)
    else $error("handshake while clock enable low");
  a_literal_load: assert property (lit |-> ##4 accum_out == $past(kval, 4))
    else $error("literal not loaded into accumulator");
  a_flags_untouched: assert property (flagfree |-> ##4 flags_out == $past(flags_out, 4))
    else $error("flags changed by flag-free operation");
  a_rotate_z_dc: assert property
    (rot |-> ##4 ((flags_out ^ $past(flags_out, 4)) & 3'h6) == 3'h0)
    else $error("rotate touched zero or nibble flag");
  a_logic_keeps_c: assert property
    (zonly |-> ##4 ((flags_out ^ $past(flags_out, 4)) & 3'h3) == 3'h0)
    else $error("logic op touched carry or nibble flag");
  a_store_keeps_w: assert property (store |-> ##4 accum_out == $past(accum_out, 4))
    else $error("store changed accumulator");
  a_dir_at_q4: assert property
    ($changed(dir_out) |-> phase_out == 4'b0001 && $past(phase_out) == 4'b1000)
    else $error("direction write outside last quarter");
  a_accum_at_q4: assert property
    ($changed(accum_out) && !$past(acc) |-> phase_out == 4'b0001)
    else $error("accumulator written outside last quarter");
endmodule : bopx_core_checker

bind bopx_core bopx_core_checker u_chk (.pclk, .presetn, .ce, .psel, .penable, .pready,
  .instr_data, .instr_valid, .instr_ready, .accum_out, .flags_out, .phase_out, .dir_out);

`default_nettype wire

// ===== bopx_prog_mem.sv
// Program memory model handing 14-bit words to the executor.
// Assumes the bench pushes words and may stall delivery at random.
`timescale 1ns/1ps
`default_nettype none

module bopx_prog_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [13:0] push_word,
  input wire logic stall,
  input wire logic instr_ready,
  output logic [13:0] instr_data,
  output logic instr_valid
);
  logic [13:0] mem [64];
  logic [5:0] rd_q;
  logic [5:0] wr_q;

  initial foreach (mem[i]) mem[i] = 14'h0000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 6'h00;
      wr_q <= 6'h00;
    end else begin
      if (push) begin
        mem[wr_q] <= push_word;
        wr_q <= wr_q + 6'h01;
      end
      if (instr_valid && instr_ready) begin
        rd_q <= rd_q + 6'h01;
      end
    end
  end

  // Idle data line shows the inverse of the last word, never stale data
  always_comb begin
    instr_valid = (rd_q != wr_q) && !stall;
    instr_data = instr_valid ? mem[rd_q] : ~mem[rd_q - 6'h01];
  end
endmodule : bopx_prog_mem

`default_nettype wire

// ===== tb_bopx_core.sv
// Self-checking bench: random instructions against an integer model.
// Assumes the program memory model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_bopx_core;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, accum_out, wv, fv, lo;
  logic [31:0] pwdata, prdata, rv;
  logic instr_valid, instr_ready, push, stall;
  logic [13:0] instr_data, push_word;
  logic [2:0] flags_out, sv;
  logic [3:0] phase_out;
  logic [23:0] dir_out;
  logic [5:0] hi;
  // Last two are unknown encodings that must run as no-ops
  logic [5:0] ops [11] = '{6'h04, 6'h08, 6'h30, 6'h0d, 6'h0c, 6'h02, 6'h0e, 6'h00, 6'h00,
    6'h1a, 6'h34};
  int num_errors, checks, zf, nf, cf, mw;
  int mf [128];
  int md [3];

  bopx_core DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_data, .instr_valid, .instr_ready, .accum_out, .flags_out,
    .phase_out, .dir_out);
  bopx_prog_mem u_mem (.pclk, .presetn, .push, .push_word, .stall, .instr_ready,
    .instr_data, .instr_valid);

  // Clock and a memory that stalls about one cycle in four
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) stall <= ($urandom % 4) == 0;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Queue one word and apply it to the model
  task put(input logic [13:0] iw);
    int a, f, r;
    a = iw[6:0];
    f = mf[a];
    r = -1;
    push <= 1'b1;
    push_word <= iw;
    @(posedge pclk);
    if (iw[13:10] == 4'hc) mw = iw[7:0];
    else if (iw[13:12] == 2'h0) begin
      case (iw[11:8])
        4'h4: begin r = mw | f; zf = r == 0; end
        4'h8: begin r = f; zf = r == 0; end
        4'hd: begin r = ((f << 1) | cf) & 255; cf = f >> 7; end
        4'hc: begin r = (f >> 1) | (cf << 7); cf = f & 1; end
        4'h2: begin
          r = f + (~mw & 255) + 1;
          cf = r >> 8;
          nf = ((f & 15) + (~mw & 15) + 1) >> 4;
          r = r & 255;
          zf = r == 0;
        end
        4'he: r = ((f & 15) << 4) | (f >> 4);
        4'h0: if (iw[7]) mf[a] = mw;
          else if (iw[6:3] == 4'hc && iw[2:0] >= 5) md[iw[2:0] - 5] = mw;
        default: ;
      endcase
    end
    if (r >= 0) begin
      if (iw[7]) mf[a] = r;
      else mw = r;
    end
  endtask : put

  // Wait for k takes, then the four quarters, and compare results
  task go(input int k);
    push <= 1'b0;
    while (k > 0) begin
      if (instr_valid && instr_ready) k--;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
    chk("accum", accum_out, mw);
    chk("flags", flags_out, {zf[0], nf[0], cf[0]});
    chk("dir", dir_out, {8'(md[2]), 8'(md[1]), 8'(md[0])});
  endtask : go

  task results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    #300000;
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(32'h5461));
    {presetn, psel, penable, pwrite, push} = 5'h00;
    {paddr, pwdata, push_word} = '0;
    ce = 1'b1;
    zf = 0;
    nf = 0;
    cf = 0;
    mw = 0;
    foreach (mf[i]) mf[i] = 0;
    foreach (md[i]) md[i] = 255;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, read-only and unmapped places
    // software writes to the direction regs by address are ignored
    apb(1'b1, bopx_pkg::REG_DIR, 32'h0);
    apb(1'b0, bopx_pkg::REG_DIR, 32'h0);
    chk("dir reg", rv, 32'h00ffffff);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {rv[30:0], perr}, 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b1, bopx_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 300; i++) begin
      hi = ops[$urandom % 11];
      lo = 8'($urandom);
      if (i % 16 == 0) lo[6:0] = 7'h7f;
      if (hi == 6'h30) hi[1:0] = 2'($urandom);
      else if (hi == 6'h00 && !lo[7]) lo[6:3] = 4'hc;
      {wv, fv, sv} = 19'($urandom);
      apb(1'b1, bopx_pkg::REG_ACCUM, {24'h0, wv});
      apb(1'b1, bopx_pkg::REG_STATUS, {29'h0, sv});
      apb(1'b1, bopx_pkg::REG_WADDR, {25'h0, lo[6:0]});
      apb(1'b1, bopx_pkg::REG_WDATA, {24'h0, fv});
      mw = wv;
      zf = sv[2];
      nf = sv[1];
      cf = sv[0];
      mf[lo[6:0]] = fv;
      put({hi, lo});
      go(1);
      apb(1'b0, bopx_pkg::REG_WDATA, 32'h0);
      chk("file", rv, mf[lo[6:0]]);
    end
    put(14'h30a5);
    put(14'h0085);
    go(2);
    apb(1'b1, bopx_pkg::REG_WADDR, 32'h5);
    apb(1'b0, bopx_pkg::REG_WDATA, 32'h0);
    chk("b2b file", rv, 32'ha5);
    // Mid-run reset brings every visible register back to its reset value
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst accum", accum_out, 32'h0);
    chk("rst flags", flags_out, 32'h0);
    chk("rst dir", dir_out, 32'h00ffffff);
    results();
  end
endmodule : tb_bopx_core

`default_nettype wire
